// File: pkg/mwr_pkg.sv
// Purpose: Constants for the wake, edge, timer-high and timer0 mode register slice
// Assumes: 8-bit special-function register space, byte-wide data
// Notes:   Offsets are register-space byte addresses
package mwr_pkg;
  localparam logic [7:0] ADDR_WAKE    = 8'h15;
  localparam logic [7:0] ADDR_EDGE    = 8'h18;
  localparam logic [7:0] ADDR_T1HI    = 8'h19;
  localparam logic [7:0] ADDR_RFC     = 8'h1b;
  localparam logic [7:0] ADDR_T3HI    = 8'h1c;
  localparam logic [7:0] ADDR_T3IRQ   = 8'h1f;
  localparam logic [7:0] RST_WAKE     = 8'hff;
  localparam logic [5:0] RST_EDGE     = 6'h05;
  localparam logic [7:0] RST_TIMER0_MODE_PRESCALER     = 8'h3f;
  localparam logic [1:0] EDGE_RISE    = 2'h1;
  localparam logic [1:0] EDGE_FALL    = 2'h2;
  localparam logic [1:0] EDGE_BOTH    = 2'h3;
  localparam int         BIT_TIMER3_UNDERFLOW_FLAG     = 4;
  localparam int         BIT_TIMER3_UNDERFLOW_IRQ_EN     = 0;
  localparam int         BIT_MEASURE_ENABLE    = 7;
  localparam int         BIT_T0_LCK   = 7;
  localparam int         BIT_T0_CS    = 5;
  localparam int         BIT_T0_CE    = 4;
  localparam int         BIT_T0_PSA   = 3;
endpackage

// File: src/mwr_regs.sv
// Purpose: Register slice: wake enables, edge select, timer high bits, RES_FREQ_MEASURE_CTRL, Timer3 irq, Timer0 mode
// Assumes: CPU access on ref_clk; pins and flag events already synchronous
// Notes:   Counting cores, PWM, watchdog and measurement engine live elsewhere
// What this block does
// - Eight port A wake enables, set lets pin wake, reset all ones
// - Irq0 edge code: 01 rise, 10 fall, 11 both, 00 reserved
// - Irq1 edge code uses same coding in its own field
// - Irq0 select routes PB0 as interrupt input, else general pin
// - Irq1 select routes PB1/PA2 as interrupt input, else general pin
// - Timer1 high write sets reload bits 9..8; read returns live count bits
// - Same register holds PWM2 and PWM1 duty high bits
// - Timer3 high write sets reload bits 9..8; read returns live count bits
// - Timer3 register holds PWM4 and PWM3 duty high bits
// - RES_FREQ_MEASURE_CTRL bit 7 enables measurement, resets to zero
// - Four-bit pad code picks PA0..PA7 or PB0..PB5
// - Timer3 underflow sets bit 4 flag, held until firmware write clears
// - Bit 0 enables Timer3 underflow interrupt, resets zero
// - Timer0 mode register reached only by two dedicated instructions
// - Timer0 prescale divides by two to power code plus one
// - Watchdog prescale: 2^code in reset mode, 2^(code+1) interrupt mode
// - Assignment bit gives prescaler to watchdog when set, resets one
// - Edge bit set counts falling, clear counts rising external edges
// - Edge selection also applies to low-frequency oscillator source
// - Source bit picks instruction clock or external source; bit 7 then picks external pin or low oscillator
`timescale 1ns/1ps
module mwr_regs (
  input  wire logic       ref_clk,         // Instruction clock
  input  wire logic       rst_n,           // Async reset, active low
  input  wire logic [7:0] reg_addr,        // Data-space address
  input  wire logic       reg_wr,          // Data-space write strobe
  input  wire logic [7:0] reg_wdata,       // Write data
  output logic      [7:0] reg_rdata,       // Read data, combinational
  input  wire logic       timer0_mode_prescaler_wr,         // Mode-write instruction strobe
  output logic      [7:0] timer0_mode_prescaler_rdata,      // Mode-read instruction data
  input  wire logic [1:0] timer1_count_hi, // Live Timer1 bits 9..8
  input  wire logic [1:0] timer3_count_hi, // Live Timer3 bits 9..8
  input  wire logic       timer3_underflow,// Timer3 underflow pulse
  input  wire logic       wdt_irq_mode,    // Watchdog in interrupt mode
  input  wire logic [7:0] porta_pins,      // Synchronised port A levels
  input  wire logic [5:0] portb_pins,      // Synchronised port B levels
  output logic      [7:0] pin_wake_enable, // Port A wake enables
  output logic      [1:0] timer1_high_bits,// Timer1 reload bits 9..8
  output logic      [1:0] timer3_high_bits,// Timer3 reload bits 9..8
  output logic      [1:0] pwm_ch1_duty_high,
  output logic      [1:0] pwm_ch2_duty_high,
  output logic      [1:0] pwm_ch3_duty_high,
  output logic      [1:0] pwm_ch4_duty_high,
  output logic            measure_enable,  // Measurement enable
  output logic            measure_pad,     // Selected pad level
  output logic            irq0_pin_select, // PB0 used as irq0
  output logic            irq1_pin_select, // PB1/PA2 used as irq1
  output logic            irq0_trigger,    // Irq0 edge event pulse
  output logic            irq1_trigger,    // Irq1 edge event pulse
  output logic            timer3_underflow_flag,
  output logic            timer3_irq,      // Flag gated by enable
  output logic            prescaler_assign,// 1 watchdog, 0 Timer0
  output logic      [8:0] prescale_ratio,  // Divide ratio, 1..256
  output logic      [1:0] timer0_clk_src,  // 0 inst, 1 pin, 2 low osc
  output logic            timer0_edge_select // 1 falling, 0 rising
);
  logic [7:0] wake;
  logic [5:0] edge_sel;
  logic [1:0] t1_hi;
  logic [3:0] pwm12;
  logic [1:0] t3_hi;
  logic [3:0] pwm34;
  logic       rfc_en;
  logic [3:0] rfc_psel;
  logic       t3_flag;
  logic       t3_ie;
  logic [7:0] timer0_mode_prescaler;
  logic       irq0_d;
  logic       irq1_d;

  // Address decode
  wire wr_wake = reg_wr && reg_addr == mwr_pkg::ADDR_WAKE;
  wire wr_edge = reg_wr && reg_addr == mwr_pkg::ADDR_EDGE;
  wire wr_t1hi = reg_wr && reg_addr == mwr_pkg::ADDR_T1HI;
  wire wr_rfc  = reg_wr && reg_addr == mwr_pkg::ADDR_RFC;
  wire wr_t3hi = reg_wr && reg_addr == mwr_pkg::ADDR_T3HI;
  wire wr_t3ir = reg_wr && reg_addr == mwr_pkg::ADDR_T3IRQ;

  // Register writes; unused bits are not stored, except bit 6 of the Timer0 mode byte
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake     <= mwr_pkg::RST_WAKE;
      edge_sel <= mwr_pkg::RST_EDGE;
      t1_hi    <= 2'h0;
      pwm12    <= 4'h0;
      rfc_en   <= 1'b0;
      rfc_psel <= 4'h0;
      t3_hi    <= 2'h0;
      pwm34    <= 4'h0;
      t3_ie    <= 1'b0;
      timer0_mode_prescaler     <= mwr_pkg::RST_TIMER0_MODE_PRESCALER;
    end else begin
      if (wr_wake) wake <= reg_wdata;
      if (wr_edge) edge_sel <= reg_wdata[5:0];
      if (wr_t1hi) begin
        t1_hi <= reg_wdata[5:4];
        pwm12 <= reg_wdata[3:0];
      end
      if (wr_rfc) begin
        rfc_en   <= reg_wdata[mwr_pkg::BIT_MEASURE_ENABLE];
        rfc_psel <= reg_wdata[3:0];
      end
      if (wr_t3hi) begin
        t3_hi <= reg_wdata[5:4];
        pwm34 <= reg_wdata[3:0];
      end
      if (wr_t3ir) t3_ie <= reg_wdata[mwr_pkg::BIT_TIMER3_UNDERFLOW_IRQ_EN];
      if (timer0_mode_prescaler_wr) timer0_mode_prescaler <= reg_wdata;
    end
  end

  // Underflow flag: a new underflow wins over a firmware clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) t3_flag <= 1'b0;
    else if (timer3_underflow) t3_flag <= 1'b1;
    else if (wr_t3ir) t3_flag <= reg_wdata[mwr_pkg::BIT_TIMER3_UNDERFLOW_FLAG];
  end

  // Previous levels of the interrupt pins for edge detection
  wire irq0_lvl = portb_pins[0];
  wire irq1_lvl = portb_pins[1] | porta_pins[2];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq0_d <= 1'b0;
      irq1_d <= 1'b0;
    end else begin
      irq0_d <= irq0_lvl;
      irq1_d <= irq1_lvl;
    end
  end

  // Edge decode; code 00 yields nothing
  wire [1:0] c0 = edge_sel[1:0];
  wire [1:0] c1 = edge_sel[3:2];
  wire r0 = irq0_lvl & ~irq0_d;
  wire f0 = ~irq0_lvl & irq0_d;
  wire r1 = irq1_lvl & ~irq1_d;
  wire f1 = ~irq1_lvl & irq1_d;
  assign irq0_pin_select = edge_sel[4];
  assign irq1_pin_select = edge_sel[5];
  assign irq0_trigger = irq0_pin_select & ((c0[0] & r0) | (c0[1] & f0));
  assign irq1_trigger = irq1_pin_select & ((c1[0] & r1) | (c1[1] & f1));

  // Outputs from registers
  assign pin_wake_enable   = wake;
  assign timer1_high_bits  = t1_hi;
  assign timer3_high_bits  = t3_hi;
  assign pwm_ch1_duty_high = pwm12[1:0];
  assign pwm_ch2_duty_high = pwm12[3:2];
  assign pwm_ch3_duty_high = pwm34[1:0];
  assign pwm_ch4_duty_high = pwm34[3:2];
  assign measure_enable    = rfc_en;
  assign timer3_underflow_flag = t3_flag;
  assign timer3_irq        = t3_flag & t3_ie;

  // Pad mux; codes above 1101 select nothing
  wire [13:0] pads = {portb_pins, porta_pins};
  assign measure_pad = (rfc_psel <= 4'hd) ? pads[rfc_psel] : 1'b0;

  // Timer0 mode decode
  wire [2:0] rate = timer0_mode_prescaler[2:0];
  wire       wdt_rst_div = timer0_mode_prescaler[mwr_pkg::BIT_T0_PSA] & ~wdt_irq_mode;
  assign prescaler_assign   = timer0_mode_prescaler[mwr_pkg::BIT_T0_PSA];
  assign prescale_ratio     = wdt_rst_div ? (9'h001 << rate) : (9'h002 << rate);
  assign timer0_edge_select = timer0_mode_prescaler[mwr_pkg::BIT_T0_CE];
  assign timer0_clk_src = !timer0_mode_prescaler[mwr_pkg::BIT_T0_CS] ? 2'h0 :
                          (timer0_mode_prescaler[mwr_pkg::BIT_T0_LCK] ? 2'h2 : 2'h1);
  assign timer0_mode_prescaler_rdata = timer0_mode_prescaler;

  // Read mux; count bits come live from the timers
  always_comb begin
    unique case (reg_addr)
      mwr_pkg::ADDR_WAKE:  reg_rdata = wake;
      mwr_pkg::ADDR_EDGE:  reg_rdata = {2'h0, edge_sel};
      mwr_pkg::ADDR_T1HI:  reg_rdata = {2'h0, timer1_count_hi, pwm12};
      mwr_pkg::ADDR_RFC:   reg_rdata = {rfc_en, 3'h0, rfc_psel};
      mwr_pkg::ADDR_T3HI:  reg_rdata = {2'h0, timer3_count_hi, pwm34};
      mwr_pkg::ADDR_T3IRQ: reg_rdata = {3'h0, t3_flag, 3'h0, t3_ie};
      default:             reg_rdata = 8'h00;
    endcase
  end

  // Checks
  property p_wake_reset;
    @(posedge ref_clk) $rose(rst_n) |-> pin_wake_enable == 8'hff;
  endproperty
  a_wake_reset: assert property (p_wake_reset) else $error("wake reset wrong");
  property p_flag_sticky;
    @(posedge ref_clk) disable iff (!rst_n) timer3_underflow |=> timer3_underflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag not set");
  property p_flag_hold;
    @(posedge ref_clk) disable iff (!rst_n) timer3_underflow_flag && !wr_t3ir |=> timer3_underflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rst_n) timer3_irq |-> timer3_underflow_flag && t3_ie;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
  property p_t1_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_t1hi |=> timer1_high_bits == $past(reg_wdata[5:4]);
  endproperty
  a_t1_write: assert property (p_t1_write) else $error("t1 high wrong");
  property p_t3_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_t3hi |=> pwm_ch4_duty_high == $past(reg_wdata[3:2]);
  endproperty
  a_t3_write: assert property (p_t3_write) else $error("pwm4 wrong");
  property p_reserved;
    @(posedge ref_clk) disable iff (!rst_n) c0 == 2'h0 |-> !irq0_trigger;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved fired");
  property p_t0_ratio;
    @(posedge ref_clk) disable iff (!rst_n) !prescaler_assign |-> prescale_ratio == (9'h002 << rate);
  endproperty
  a_t0_ratio: assert property (p_t0_ratio) else $error("ratio wrong");
  c_flag: cover property (@(posedge ref_clk) timer3_underflow ##1 wr_t3ir);
  c_irq0: cover property (@(posedge ref_clk) irq0_trigger);
  c_wdt: cover property (@(posedge ref_clk) wdt_rst_div && rate == 3'h7);
  c_irq1: cover property (@(posedge ref_clk) irq1_trigger && c1 == mwr_pkg::EDGE_FALL);
  c_pad: cover property (@(posedge ref_clk) rfc_en && rfc_psel == 4'hd && measure_pad);

  // Wake byte lands whole one edge after its strobe
  property p_wake_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_wake |=> pin_wake_enable == $past(reg_wdata);
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("wake write wrong");
  // PWM1 and PWM2 duty high bits share the low nibble
  property p_pwm12_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_t1hi |=> {pwm_ch2_duty_high, pwm_ch1_duty_high} == $past(reg_wdata[3:0]);
  endproperty
  a_pwm12_write: assert property (p_pwm12_write) else $error("pwm12 wrong");
  // Timer3 reload high bits come from bits 5..4
  property p_t3hi_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_t3hi |=> timer3_high_bits == $past(reg_wdata[5:4]);
  endproperty
  a_t3hi_write: assert property (p_t3hi_write) else $error("t3 high wrong");
  // PWM3 duty high bits sit in bits 1..0
  property p_pwm3_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_t3hi |=> pwm_ch3_duty_high == $past(reg_wdata[1:0]);
  endproperty
  a_pwm3_write: assert property (p_pwm3_write) else $error("pwm3 wrong");
  // Measurement enable follows bit 7 of its write
  property p_rfc_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_rfc |=> measure_enable == $past(reg_wdata[7]);
  endproperty
  a_rfc_write: assert property (p_rfc_write) else $error("rfc enable wrong");
  // Codes past the last pad must give a quiet output
  property p_pad_off;
    @(posedge ref_clk) disable iff (!rst_n) rfc_psel > 4'hd |-> !measure_pad;
  endproperty
  a_pad_off: assert property (p_pad_off) else $error("pad not quiet");
  // Clear by write sticks when no underflow competes
  property p_flag_clear;
    @(posedge ref_clk) disable iff (!rst_n) wr_t3ir && !reg_wdata[4] && !timer3_underflow |=> !timer3_underflow_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
  // Enable bit follows bit 0 of its write
  property p_ie_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_t3ir |=> t3_ie == $past(reg_wdata[0]);
  endproperty
  a_ie_write: assert property (p_ie_write) else $error("irq enable wrong");
  // Pin-select bits come from bits 5..4 of the edge write
  property p_sel_write;
    @(posedge ref_clk) disable iff (!rst_n) wr_edge |=> {irq1_pin_select, irq0_pin_select} == $past(reg_wdata[5:4]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("pin select wrong");
  // A rising pin with rising code must trigger; past reset edge skipped
  property p_irq0_rise;
    @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) && irq0_pin_select && c0 == mwr_pkg::EDGE_RISE && irq0_lvl && !$past(irq0_lvl) |-> irq0_trigger;
  endproperty
  a_irq0_rise: assert property (p_irq0_rise) else $error("irq0 rise missed");
  // A falling irq1 level with falling code must trigger
  property p_irq1_fall;
    @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) && irq1_pin_select && c1 == mwr_pkg::EDGE_FALL && !irq1_lvl && $past(irq1_lvl) |-> irq1_trigger;
  endproperty
  a_irq1_fall: assert property (p_irq1_fall) else $error("irq1 fall missed");
  // Watchdog reset mode divides by two to the power code
  property p_wdt_ratio;
    @(posedge ref_clk) disable iff (!rst_n) prescaler_assign && !wdt_irq_mode |-> prescale_ratio == (9'h001 << rate);
  endproperty
  a_wdt_ratio: assert property (p_wdt_ratio) else $error("wdt ratio wrong");
  // Source bit clear always means instruction clock
  property p_t0_src;
    @(posedge ref_clk) disable iff (!rst_n) !timer0_mode_prescaler[mwr_pkg::BIT_T0_CS] |-> timer0_clk_src == 2'h0;
  endproperty
  a_t0_src: assert property (p_t0_src) else $error("clock source wrong");
  // Mode instruction writes the whole byte
  property p_t0_write;
    @(posedge ref_clk) disable iff (!rst_n) timer0_mode_prescaler_wr |=> timer0_mode_prescaler_rdata == $past(reg_wdata);
  endproperty
  a_t0_write: assert property (p_t0_write) else $error("mode write wrong");
  // Mode register leaves reset with the watchdog owning the prescaler
  property p_t0_reset;
    @(posedge ref_clk) $rose(rst_n) |-> timer0_mode_prescaler_rdata == mwr_pkg::RST_TIMER0_MODE_PRESCALER;
  endproperty
  a_t0_reset: assert property (p_t0_reset) else $error("mode reset wrong");
  // Timer1 read returns the live count, not the stored reload
  property p_t1_read;
    @(posedge ref_clk) disable iff (!rst_n) reg_addr == mwr_pkg::ADDR_T1HI |-> reg_rdata[5:4] == timer1_count_hi;
  endproperty
  a_t1_read: assert property (p_t1_read) else $error("t1 read wrong");
endmodule

// File: testbench/mwr_tb.sv
// Purpose: Self-checking bench for the mwr_regs register slice
// Assumes: Inputs change on ref_clk rising edge by NBA; reads are combinational
// Notes:   Edge pulses are counted over three cycles so pulse timing is not assumed
`timescale 1ns/1ps
module testbench;
  logic       ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, timer0_mode_prescaler_wr = 1'b0;
  logic       timer3_underflow = 1'b0, wdt_irq_mode = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, porta_pins = 8'h00;
  logic [5:0] portb_pins = 6'h00;
  logic [1:0] timer1_count_hi = 2'h1, timer3_count_hi = 2'h2;
  logic [7:0] reg_rdata, timer0_mode_prescaler_rdata, pin_wake_enable;
  logic [1:0] timer1_high_bits, timer3_high_bits, timer0_clk_src;
  logic [1:0] pwm_ch1_duty_high, pwm_ch2_duty_high, pwm_ch3_duty_high, pwm_ch4_duty_high;
  logic       measure_enable, measure_pad, irq0_pin_select, irq1_pin_select, irq0_trigger, irq1_trigger;
  logic       timer3_underflow_flag, timer3_irq, prescaler_assign, timer0_edge_select;
  logic [8:0] prescale_ratio, r0, r1, f0, f1;
  int         n_fail = 0, comparisons = 0;
  mwr_regs mwr_regs_inst (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .timer0_mode_prescaler_wr, .timer0_mode_prescaler_rdata,
    .timer1_count_hi, .timer3_count_hi, .timer3_underflow, .wdt_irq_mode, .porta_pins, .portb_pins,
    .pin_wake_enable, .timer1_high_bits, .timer3_high_bits, .pwm_ch1_duty_high, .pwm_ch2_duty_high,
    .pwm_ch3_duty_high, .pwm_ch4_duty_high, .measure_enable, .measure_pad, .irq0_pin_select,
    .irq1_pin_select, .irq0_trigger, .irq1_trigger, .timer3_underflow_flag, .timer3_irq,
    .prescaler_assign, .prescale_ratio, .timer0_clk_src, .timer0_edge_select);
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  task automatic tally_and_finish;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobes drop at the taking edge, so back-to-back calls leave one idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic mode);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    if (mode) timer0_mode_prescaler_wr <= 1'b1;
    else reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr  <= 1'b0;
    timer0_mode_prescaler_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    #1;
    chk(9'(reg_rdata), 9'(e));
  endtask
  task automatic pins_to(input logic v, output logic [8:0] n0, output logic [8:0] n1);
    @(posedge ref_clk);
    portb_pins <= {4'h0, v, v};
    n0 = 9'h000;
    n1 = 9'h000;
    repeat (3) begin
      #1;
      n0 += 9'(irq0_trigger);
      n1 += 9'(irq1_trigger);
      @(posedge ref_clk);
    end
  endtask
  task automatic uf_pulse;
    @(posedge ref_clk);
    timer3_underflow <= 1'b1;
    @(posedge ref_clk);
    timer3_underflow <= 1'b0;
    #1;
  endtask
  task automatic t_reset;
    rd(8'h15, mwr_pkg::RST_WAKE);
    rd(8'h18, {2'b00, mwr_pkg::RST_EDGE});
    rd(8'h1f, 8'h00);
    rd(8'h1b, 8'h00);
    rd(8'h20, 8'h00);
    chk(9'(timer0_mode_prescaler_rdata), 9'(mwr_pkg::RST_TIMER0_MODE_PRESCALER));
    chk(9'(prescaler_assign), 9'h001);
    $display("reset test done");
  endtask
  task automatic t_wake;
    wr(8'h15, 8'h5a, 1'b0);
    chk(9'(pin_wake_enable), 9'h05a);
    rd(8'h15, 8'h5a);
    $display("wake test done");
  endtask
  // Same code in both fields; reserved 00 must give no pulse
  task automatic t_edge;
    for (int c = 0; c < 4; c++) begin
      wr(8'h18, 8'hf0 | 8'(c * 5), 1'b0);
      rd(8'h18, 8'h30 | 8'(c * 5));
      chk(9'({irq1_pin_select, irq0_pin_select}), 9'h003);
      pins_to(1'b1, r0, r1);
      pins_to(1'b0, f0, f1);
      chk(r0, 9'(c == 1 || c == 3));
      chk(f0, 9'(c >= 2));
      chk(r1, 9'(c == 1 || c == 3));
      chk(f1, 9'(c >= 2));
    end
    wr(8'h18, 8'h0f, 1'b0);
    pins_to(1'b1, r0, r1);
    chk(r0, 9'h000);
    chk(r1, 9'h000);
    $display("edge test done");
  endtask
  task automatic t_timer_hi;
    wr(8'h19, 8'hf6, 1'b0);
    chk(9'({timer1_high_bits, pwm_ch2_duty_high, pwm_ch1_duty_high}), 9'h036);
    rd(8'h19, 8'h16);
    wr(8'h1c, 8'hf9, 1'b0);
    chk(9'({timer3_high_bits, pwm_ch4_duty_high, pwm_ch3_duty_high}), 9'h039);
    rd(8'h1c, 8'h29);
    $display("timer high test done");
  endtask
  // One-hot pins, then inverted, for every pad code plus one unused code
  task automatic t_rfc;
    logic [13:0] sel;
    wr(8'h1b, 8'hff, 1'b0);
    rd(8'h1b, 8'h8f);
    chk(9'(measure_enable), 9'h001);
    for (int c = 0; c < 15; c++) begin
      wr(8'h80 | 8'(c), 8'h80 | 8'(c), 1'b0);
      rd(8'h80 | 8'(c), 8'h00);
      wr(8'h1b, 8'h80 | 8'(c), 1'b0);
      sel = 14'(c < 14) << c;
      @(posedge ref_clk);
      {portb_pins, porta_pins} <= sel;
      #1;
      chk(9'(measure_pad), 9'(c < 14));
      @(posedge ref_clk);
      {portb_pins, porta_pins} <= ~sel;
      #1;
      chk(9'(measure_pad), 9'h000);
    end
    @(posedge ref_clk);
    {portb_pins, porta_pins} <= 14'h0000;
    wr(8'h1b, 8'h00, 1'b0);
    chk(9'(measure_enable), 9'h000);
    $display("measure test done");
  endtask
  task automatic t_t3irq;
    wr(8'h1f, 8'h01, 1'b0);
    chk(9'(timer3_irq), 9'h000);
    uf_pulse;
    chk(9'({timer3_underflow_flag, timer3_irq}), 9'h003);
    repeat (3) @(posedge ref_clk);
    rd(8'h1f, 8'h11);
    wr(8'h1f, 8'h00, 1'b0);
    chk(9'(timer3_underflow_flag), 9'h000);
    uf_pulse;
    chk(9'({timer3_underflow_flag, timer3_irq}), 9'h002);
    wr(8'h1f, 8'h00, 1'b0);
    $display("timer3 irq test done");
  endtask
  task automatic t_timer0_mode_prescaler;
    for (int c = 0; c < 8; c++) begin
      wr(8'h00, 8'(c), 1'b1);
      chk(prescale_ratio, 9'(2 << c));
      wr(8'h00, 8'h08 | 8'(c), 1'b1);
      chk(prescale_ratio, 9'(1 << c));
      @(posedge ref_clk);
      wdt_irq_mode <= ~wdt_irq_mode;
      #1;
      chk(prescale_ratio, 9'(2 << c));
      @(posedge ref_clk);
      wdt_irq_mode <= 1'b0;
    end
    wr(8'h00, 8'h00, 1'b1);
    chk(9'({prescaler_assign, timer0_clk_src}), 9'h000);
    wr(8'h00, 8'h30, 1'b1);
    chk(9'({timer0_edge_select, timer0_clk_src}), 9'h005);
    wr(8'h00, 8'ha0, 1'b1);
    chk(9'({timer0_edge_select, timer0_clk_src}), 9'h002);
    wr(8'h00, 8'hd0, 1'b1);
    chk(9'({timer0_edge_select, timer0_clk_src}), 9'h004);
    wr(8'h00, 8'hf0, 1'b1);
    chk(9'({timer0_edge_select, timer0_clk_src}), 9'h006);
    wr(8'h00, 8'h5a, 1'b0);
    chk(9'(timer0_mode_prescaler_rdata), 9'h0f0);
    $display("timer0 mode test done");
  endtask
  // Main sequence after a 10-cycle reset
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_wake;
    t_edge;
    t_timer_hi;
    t_rfc;
    t_t3irq;
    t_timer0_mode_prescaler;
    tally_and_finish;
  end
  // Hang guard
  initial begin
    #100000;
    n_fail++;
    tally_and_finish;
  end
endmodule
